// file: dtb_top.sv
`timescale 1ns/1ps
module dtb_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sub_oscillator_clock,
  input wire logic tmr0_count_pin,
  input wire logic tmr1_count_pin,
  input wire logic external_gate_pin_0,
  input wire logic external_gate_pin_1,
  input wire logic tmr0_int_serviced,
  input wire logic tmr1_int_serviced,
  input wire logic key_tone,
  output logic tone_output_pin_o,
  output logic tone_output_pin_oe,
  output logic irq
);
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction : fell

  function automatic logic base_tick(input logic [1:0] sel, input logic [9:0] div,
                                     input logic sub_fall);
    case (sel)
      dtb_pkg::SRC_DIV4: base_tick = (div & dtb_pkg::DIV4_MASK) == dtb_pkg::DIV4_MASK;
      dtb_pkg::SRC_DIV64: base_tick = (div & dtb_pkg::DIV64_MASK) == dtb_pkg::DIV64_MASK;
      dtb_pkg::SRC_DIV1024: base_tick = div == dtb_pkg::DIV1024_MASK;
      default: base_tick = sub_fall;
    endcase
  endfunction : base_tick

  // ----------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic [3:0] timebase_select_reg;
  logic [7:0] tone_config_reg;
  logic [1:0] irq_mask_reg;
  logic tmr0_overflow_flag;
  logic tmr1_overflow_flag;
  logic [1:0] pend_reg;
  logic [9:0] div_reg;
  dtb_pkg::dtb_phase_t phase_reg;
  logic sub_prev_reg;
  logic pin0_prev_reg;
  logic pin1_prev_reg;
  logic tone_reg;
  logic [7:0] tmr0_lower_byte;
  logic [7:0] tmr0_upper_byte;
  logic [7:0] tmr1_lower_byte;
  logic [7:0] tmr1_upper_byte;
  logic [1:0] unit_ovf;
  logic [1:0] tick;
  logic [1:0] run_ok;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rdata_next;
  logic [7:0] vec_next;
  logic phase2;

  // ----------------------------------------------------------
  // APB slave: setup, then two access cycles
  // ----------------------------------------------------------
  // pready from a flop keeps the output clean at the cost of a wait state
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & ~pready & ~pwrite;
  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      dtb_pkg::ADDR_CTRL, dtb_pkg::ADDR_TBSEL, dtb_pkg::ADDR_TONE, dtb_pkg::ADDR_CNT0,
      dtb_pkg::ADDR_CNT1, dtb_pkg::ADDR_STAT, dtb_pkg::ADDR_MASK,
      dtb_pkg::ADDR_VEC: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Highest pending unmasked source wins the vector, timer 0 first
  always_comb begin
    if (tmr0_overflow_flag & irq_mask_reg[0]) begin
      vec_next = dtb_pkg::VEC_TMR0;
    end else if (tmr1_overflow_flag & irq_mask_reg[1]) begin
      vec_next = dtb_pkg::VEC_TMR1;
    end else begin
      vec_next = 8'h00;
    end
  end

  // Read data mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      dtb_pkg::ADDR_CTRL: rdata_next = {16'h0000, ctrl_reg};
      dtb_pkg::ADDR_TBSEL: rdata_next = {28'h0000000, timebase_select_reg};
      dtb_pkg::ADDR_TONE: rdata_next = {24'h000000, tone_config_reg};
      dtb_pkg::ADDR_CNT0: rdata_next = {16'h0000, tmr0_upper_byte, tmr0_lower_byte};
      dtb_pkg::ADDR_CNT1: rdata_next = {16'h0000, tmr1_upper_byte, tmr1_lower_byte};
      dtb_pkg::ADDR_STAT: rdata_next = {30'h0, tmr1_overflow_flag, tmr0_overflow_flag};
      dtb_pkg::ADDR_MASK: rdata_next = {30'h0, irq_mask_reg};
      dtb_pkg::ADDR_VEC: rdata_next = {24'h000000, vec_next};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Bus answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (rd_en) begin
        prdata <= rdata_next;
      end
    end
  end

  // Software-written control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= dtb_pkg::CTRL_RST;
      timebase_select_reg <= dtb_pkg::TBSEL_RST;
      tone_config_reg <= dtb_pkg::TONE_RST;
      irq_mask_reg <= 2'h0;
    end else if (wr_en) begin
      case (paddr)
        dtb_pkg::ADDR_CTRL: ctrl_reg <= pwdata[15:0] & dtb_pkg::CTRL_WMASK;
        dtb_pkg::ADDR_TBSEL: timebase_select_reg <= pwdata[3:0];
        dtb_pkg::ADDR_TONE: tone_config_reg <= pwdata[7:0];
        dtb_pkg::ADDR_MASK: irq_mask_reg <= pwdata[1:0];
        default: irq_mask_reg <= irq_mask_reg;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Prescaler, machine cycle and pin edges
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= dtb_pkg::DIV_RST;
      sub_prev_reg <= 1'b0;
      pin0_prev_reg <= 1'b0;
      pin1_prev_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 10'h001;
      sub_prev_reg <= sub_oscillator_clock;
      pin0_prev_reg <= tmr0_count_pin;
      pin1_prev_reg <= tmr1_count_pin;
    end
  end

  // Machine cycle of four clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= dtb_pkg::DTB_PH1;
    end else begin
      case (phase_reg)
        dtb_pkg::DTB_PH1: phase_reg <= dtb_pkg::DTB_PH2;
        dtb_pkg::DTB_PH2: phase_reg <= dtb_pkg::DTB_PH3;
        dtb_pkg::DTB_PH3: phase_reg <= dtb_pkg::DTB_PH4;
        default: phase_reg <= dtb_pkg::DTB_PH1;
      endcase
    end
  end
  assign phase2 = (phase_reg == dtb_pkg::DTB_PH2);

  // ----------------------------------------------------------
  // Count enables and the two timers
  // ----------------------------------------------------------
  assign run_ok[0] = ctrl_reg[dtb_pkg::CTRL_RUN]
    & (~ctrl_reg[dtb_pkg::CTRL_GATE] | external_gate_pin_0);
  assign run_ok[1] = ctrl_reg[dtb_pkg::CTRL_T1 + dtb_pkg::CTRL_RUN]
    & (~ctrl_reg[dtb_pkg::CTRL_T1 + dtb_pkg::CTRL_GATE] | external_gate_pin_1);
  assign tick[0] = run_ok[0] & (ctrl_reg[dtb_pkg::CTRL_CSEL]
    ? fell(pin0_prev_reg, tmr0_count_pin)
    : base_tick(timebase_select_reg[1:0], div_reg, fell(sub_prev_reg, sub_oscillator_clock)));
  assign tick[1] = run_ok[1] & (ctrl_reg[dtb_pkg::CTRL_T1 + dtb_pkg::CTRL_CSEL]
    ? fell(pin1_prev_reg, tmr1_count_pin)
    : base_tick(timebase_select_reg[3:2], div_reg, fell(sub_prev_reg, sub_oscillator_clock)));

  dtb_tmr_unit u_tmr0 (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick[0]),
    .mode(ctrl_reg[dtb_pkg::CTRL_MODE +: 2]),
    .wr_cnt(wr_en && paddr == dtb_pkg::ADDR_CNT0),
    .wdata(pwdata[15:0]),
    .lower_count_byte(tmr0_lower_byte),
    .upper_count_byte(tmr0_upper_byte),
    .ovf(unit_ovf[0])
  );

  dtb_tmr_unit u_tmr1 (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick[1]),
    .mode(ctrl_reg[dtb_pkg::CTRL_T1 + dtb_pkg::CTRL_MODE +: 2]),
    .wr_cnt(wr_en && paddr == dtb_pkg::ADDR_CNT1),
    .wdata(pwdata[15:0]),
    .lower_count_byte(tmr1_lower_byte),
    .upper_count_byte(tmr1_upper_byte),
    .ovf(unit_ovf[1])
  );

  // ----------------------------------------------------------
  // Overflow capture and flags
  // ----------------------------------------------------------
  // One slot per machine cycle: an overflow while the slot is full is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 2'h0;
    end else begin
      pend_reg <= (pend_reg & ~{2{phase2}}) | unit_ovf;
    end
  end

  // Capture wins over a software or service clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr0_overflow_flag <= dtb_pkg::FLAG_RST[0];
      tmr1_overflow_flag <= dtb_pkg::FLAG_RST[1];
    end else begin
      tmr0_overflow_flag <= (tmr0_overflow_flag & ~tmr0_int_serviced
        & ~(wr_en && paddr == dtb_pkg::ADDR_STAT && pwdata[0]))
        | (pend_reg[0] & phase2);
      tmr1_overflow_flag <= (tmr1_overflow_flag & ~tmr1_int_serviced
        & ~(wr_en && paddr == dtb_pkg::ADDR_STAT && pwdata[1]))
        | (pend_reg[1] & phase2);
    end
  end

  // Level interrupt from the unmasked flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |({tmr1_overflow_flag, tmr0_overflow_flag} & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------
  // Tone output from timer 0
  // ----------------------------------------------------------
  // Toggle per reload overflow halves the reload rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_reg <= 1'b0;
    end else if (unit_ovf[0] && ctrl_reg[dtb_pkg::CTRL_MODE +: 2] == 2'h2) begin
      tone_reg <= ~tone_reg;
    end
  end

  // Pin driver; the enable float is shown as a low output enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_output_pin_o <= 1'b0;
      tone_output_pin_oe <= 1'b0;
    end else begin
      tone_output_pin_oe <= tone_config_reg[dtb_pkg::TONE_EN_BIT];
      tone_output_pin_o <= tone_config_reg[dtb_pkg::TONE_EN_BIT]
        & (tone_config_reg[dtb_pkg::TONE_SRC_BIT] ? key_tone : tone_reg);
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  flag_phase_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(tmr0_overflow_flag) |-> $past(phase_reg) == dtb_pkg::DTB_PH2)
    else $error("flag set outside phase 2");
  ovf_capture_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    unit_ovf[0] |-> ##[1:5] tmr0_overflow_flag)
    else $error("timer 0 overflow not flagged");
  gate_hold_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_reg[dtb_pkg::CTRL_GATE] && !external_gate_pin_0 |-> !tick[0])
    else $error("count while gate low");
  gate1_hold_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_reg[dtb_pkg::CTRL_T1 + dtb_pkg::CTRL_GATE] && !external_gate_pin_1
      && !(wr_en && paddr == dtb_pkg::ADDR_CNT1)
    |=> $stable({tmr1_upper_byte, tmr1_lower_byte}))
    else $error("timer 1 counted while gate low");
  service_clr_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    tmr1_int_serviced && !(pend_reg[1] && phase2) |=> !tmr1_overflow_flag)
    else $error("service did not clear flag");
  tone_off_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    !tone_config_reg[dtb_pkg::TONE_EN_BIT] |=> !tone_output_pin_oe && !tone_output_pin_o)
    else $error("tone pin driven while disabled");
  key_tone_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    tone_config_reg[dtb_pkg::TONE_EN_BIT] && tone_config_reg[dtb_pkg::TONE_SRC_BIT]
    |=> tone_output_pin_o == $past(key_tone))
    else $error("key tone not on pin");
  tone_flip_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    unit_ovf[0] && ctrl_reg[4:3] == 2'h2 |=> tone_reg != $past(tone_reg))
    else $error("tone did not toggle");
  irq_level_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    tmr0_overflow_flag && irq_mask_reg[0] |=> irq)
    else $error("unmasked flag without interrupt");
endmodule : dtb_top

// file: dtb_pkg.sv
// Functional notes
// - Two identical timers, upper and lower bytes
// - Timer clock: osc/4, /64, /1024, sub-oscillator
// - Overflow sampled at phase 2, one per cycle
// - Mode 0: 13 bits, lower top 3 ignored
// - Lower counts; upper steps on bit-4 fall
// - Mode 0 wrap to zero sets overflow flag
// - Count only if run and gate allows
// - Select bit picks clock or pin falls
// - Mode 1: full 16-bit counter
// - Mode 2: 8-bit, reload lower from upper
// - Timer 0 mode 2 drives tone pin
// - Source select high outputs key tone
// - Tone enable low floats the pin
// - Tone toggles on each timer 0 mode 2 overflow
// - Servicing clears the matching overflow flag
// - Vectors 0Bh and 1Bh; software clear too
package dtb_pkg;
  // ----------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TBSEL = 8'h04;
  localparam logic [7:0] ADDR_TONE = 8'h08;
  localparam logic [7:0] ADDR_CNT0 = 8'h0c;
  localparam logic [7:0] ADDR_CNT1 = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;
  localparam logic [7:0] ADDR_VEC = 8'h1c;
  // ----------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_GATE = 1;
  localparam int CTRL_CSEL = 2;
  localparam int CTRL_MODE = 3;
  localparam int CTRL_T1 = 8;
  localparam logic [15:0] CTRL_WMASK = 16'h1f1f;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [3:0] TBSEL_RST = 4'h0;
  localparam int TONE_SRC_BIT = 6;
  localparam int TONE_EN_BIT = 7;
  localparam logic [7:0] TONE_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [1:0] FLAG_RST = 2'h0;
  localparam logic [7:0] VEC_TMR0 = 8'h0b;
  localparam logic [7:0] VEC_TMR1 = 8'h1b;
  // ----------------------------------------------------------
  // Modes, time bases, prescaler taps
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    DTB_MODE13 = 2'h0,
    DTB_MODE16 = 2'h1,
    DTB_MODE_RELOAD = 2'h2,
    DTB_MODE_RSVD = 2'h3
  } dtb_mode_t;
  localparam logic [1:0] SRC_DIV4 = 2'h0;
  localparam logic [1:0] SRC_DIV64 = 2'h1;
  localparam logic [1:0] SRC_DIV1024 = 2'h2;
  localparam logic [1:0] SRC_SUB = 2'h3;
  localparam logic [9:0] DIV4_MASK = 10'h003;
  localparam logic [9:0] DIV64_MASK = 10'h03f;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;
  localparam logic [9:0] DIV_RST = 10'h000;
  // Machine cycle phases, one-hot
  typedef enum logic [3:0] {
    DTB_PH1 = 4'h1,
    DTB_PH2 = 4'h2,
    DTB_PH3 = 4'h4,
    DTB_PH4 = 4'h8
  } dtb_phase_t;
endpackage : dtb_pkg

// file: dtb_tmr_unit.sv
`timescale 1ns/1ps
module dtb_tmr_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic [1:0] mode,
  input wire logic wr_cnt,
  input wire logic [15:0] wdata,
  output logic [7:0] lower_count_byte,
  output logic [7:0] upper_count_byte,
  output logic ovf
);
  // ----------------------------------------------------------
  // Counting register pair
  // ----------------------------------------------------------
  // Software load beats a count in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_count_byte <= dtb_pkg::CNT_RST[7:0];
      upper_count_byte <= dtb_pkg::CNT_RST[15:8];
      ovf <= 1'b0;
    end else begin
      ovf <= 1'b0;
      if (wr_cnt) begin
        lower_count_byte <= wdata[7:0];
        upper_count_byte <= wdata[15:8];
      end else if (tick) begin
        case (mode)
          dtb_pkg::DTB_MODE13: begin
            // Top three lower bits hold whatever software wrote
            lower_count_byte[4:0] <= lower_count_byte[4:0] + 5'h01;
            if (lower_count_byte[4:0] == 5'h1f) begin
              upper_count_byte <= upper_count_byte + 8'h01;
              ovf <= (upper_count_byte == 8'hff);
            end
          end
          dtb_pkg::DTB_MODE16: begin
            {upper_count_byte, lower_count_byte} <=
              {upper_count_byte, lower_count_byte} + 16'h0001;
            ovf <= ({upper_count_byte, lower_count_byte} == 16'hffff);
          end
          dtb_pkg::DTB_MODE_RELOAD: begin
            if (lower_count_byte == 8'hff) begin
              lower_count_byte <= upper_count_byte;
              ovf <= 1'b1;
            end else begin
              lower_count_byte <= lower_count_byte + 8'h01;
            end
          end
          // Reserved code: the counter holds still
          default: begin
            ovf <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  reload_wrap_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && !wr_cnt && mode == 2'h2 && lower_count_byte == 8'hff
    |=> ovf && lower_count_byte == $past(upper_count_byte)
      && upper_count_byte == $past(upper_count_byte))
    else $error("reload mode wrap wrong");
  mode0_wrap_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && !wr_cnt && mode == 2'h0 && upper_count_byte == 8'hff
      && lower_count_byte[4:0] == 5'h1f
    |=> ovf && upper_count_byte == 8'h00 && lower_count_byte[4:0] == 5'h00
      && lower_count_byte[7:5] == $past(lower_count_byte[7:5]))
    else $error("13-bit wrap wrong");
  rsvd_hold_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr_cnt && mode == 2'h3 |=> $stable(lower_count_byte) && !ovf)
    else $error("reserved mode counted");
endmodule : dtb_tmr_unit

// file: dtb_pin_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Pin side partner: count, gate, sub-osc, key tone
// ----------------------------------------
module dtb_pin_model (
  input wire logic pclk,
  output logic sub_oscillator_clock,
  output logic tmr0_count_pin,
  output logic tmr1_count_pin,
  output logic external_gate_pin_0,
  output logic external_gate_pin_1,
  output logic key_tone
);
  logic sub_run;
  logic [3:0] sub_cnt;
  // Count pins and sub clock idle high, so releasing one never looks like a fall; gate pins and key tone idle low
  initial begin
    sub_run = 1'b0;
    sub_cnt = 4'h0;
    sub_oscillator_clock = 1'b1;
    tmr0_count_pin = 1'b1;
    tmr1_count_pin = 1'b1;
    external_gate_pin_0 = 1'b0;
    external_gate_pin_1 = 1'b0;
    key_tone = 1'b0;
  end
  // Sub clock: one fall per 16 pclk, stands high while off
  always @(posedge pclk) begin
    sub_cnt <= sub_run ? sub_cnt + 4'h1 : 4'h0;
    sub_oscillator_clock <= sub_run ? ~sub_cnt[3] : 1'b1;
  end
  // Slow falls: low and high long enough for a sampled input
  task automatic pin_falls(input int idx, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      if (idx == 0) tmr0_count_pin <= 1'b0;
      else tmr1_count_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      if (idx == 0) tmr0_count_pin <= 1'b1;
      else tmr1_count_pin <= 1'b1;
      repeat (3) @(posedge pclk);
    end
  endtask : pin_falls
  // Levels for gate pins and key tone
  task automatic set_pins(input logic g0, input logic g1, input logic kt);
    @(posedge pclk);
    external_gate_pin_0 <= g0;
    external_gate_pin_1 <= g1;
    key_tone <= kt;
  endtask : set_pins
endmodule : dtb_pin_model

// file: tb_dual_timer_counter_buzzer.sv
`timescale 1ns/1ps
module tb_dual_timer_counter_buzzer;
  typedef struct {logic [31:0] v; logic [31:0] m; logic e;} dtb_exp_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, a;
  logic pready, pslverr, sub_clk, cp0, cp1, g0, g1, kt, srv0 = 1'b0, srv1 = 1'b0;
  logic tone_o, tone_oe, irq, t;
  logic [15:0] lf = 16'h91a7;
  logic [7:0] r;
  int err_total = 0, n_tests = 0, n;
  int ks[4] = '{256, 16, 1, 64};
  dtb_exp_t exq[$];
  dtb_exp_t e;
  // ----------------------------------------
  // Clock, partner, design
  // ----------------------------------------
  always #50 pclk = ~pclk;
  dtb_pin_model pm (.pclk(pclk), .sub_oscillator_clock(sub_clk), .tmr0_count_pin(cp0),
    .tmr1_count_pin(cp1), .external_gate_pin_0(g0), .external_gate_pin_1(g1), .key_tone(kt));
  dtb_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sub_oscillator_clock(sub_clk), .tmr0_count_pin(cp0),
    .tmr1_count_pin(cp1), .external_gate_pin_0(g0), .external_gate_pin_1(g1),
    .tmr0_int_serviced(srv0), .tmr1_int_serviced(srv1), .key_tone(kt),
    .tone_output_pin_o(tone_o), .tone_output_pin_oe(tone_oe), .irq(irq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // Setup then access, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     input logic [31:0] ev, input logic [31:0] em, input logic ee);
    int w;
    if (!wr) exq.push_back('{ev, em, ee});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 20);
    // A hung slave ends the run at once
    if (w >= 20) begin
      check(32'h0, 32'h1);
      end_sim();
    end else begin
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 32'h0, 32'h0, 1'b0);
  endtask : wr
  task automatic rdx(input logic [7:0] ad, input logic [31:0] v, input logic [31:0] m);
    apb(1'b0, ad, 32'h0, v, m, 1'b0);
  endtask : rdx
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Feedback taps give a maximal 16-bit sequence
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Read watcher: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exq.pop_front();
      check(prdata & e.m, e.v & e.m);
      check({31'h0, pslverr}, {31'h0, e.e});
    end
  end
  // Watchdog sized well above the planned run
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    end_sim();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdx(8'(i * 4), 32'h0, 32'hffffffff);
    check({31'h0, tone_oe}, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    done("reset");
    lf = lfsr(lf);
    wr(dtb_pkg::ADDR_CNT0, {16'h0, lf});
    rdx(dtb_pkg::ADDR_CNT0, {16'h0, lf}, 32'hffffffff);
    wr(dtb_pkg::ADDR_CNT0, 32'h42);
    wr(dtb_pkg::ADDR_CTRL, 32'h19);
    repeat (40) @(posedge pclk);
    rdx(dtb_pkg::ADDR_CNT0, 32'h42, 32'hffff);
    done("regs");
    // Time bases: 1024 pclk cycles lie between the two captures
    for (int s = 0; s < 4; s++) begin
      wr(dtb_pkg::ADDR_TBSEL, 32'(s));
      pm.sub_run <= (s == 3);
      wr(dtb_pkg::ADDR_CTRL, 32'h09);
      rdx(dtb_pkg::ADDR_CNT0, 32'h0, 32'h0);
      a = rd;
      repeat (1020) @(posedge pclk);
      rdx(dtb_pkg::ADDR_CNT0, (a + 32'(ks[s])) & 32'hffff, 32'hffff);
    end
    pm.sub_run <= 1'b0;
    done("timebase");
    wr(dtb_pkg::ADDR_CTRL, 32'h0500);
    wr(dtb_pkg::ADDR_CNT1, 32'hfffe);
    pm.pin_falls(1, 2);
    repeat (8) @(posedge pclk);
    rdx(dtb_pkg::ADDR_CNT1, 32'h00e0, 32'hffff);
    rdx(dtb_pkg::ADDR_STAT, 32'h2, 32'h3);
    wr(dtb_pkg::ADDR_MASK, 32'h2);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    rdx(dtb_pkg::ADDR_VEC, 32'h1b, 32'hff);
    srv1 <= 1'b1;
    @(posedge pclk);
    srv1 <= 1'b0;
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    rdx(dtb_pkg::ADDR_STAT, 32'h0, 32'h3);
    done("mode0");
    // Both timers gated; timer 0 counts its own pin in 13-bit mode
    wr(dtb_pkg::ADDR_CTRL, 32'h0f07);
    wr(dtb_pkg::ADDR_CNT0, 32'h0);
    wr(dtb_pkg::ADDR_CNT1, 32'hffff);
    pm.pin_falls(1, 3);
    pm.pin_falls(0, 2);
    repeat (8) @(posedge pclk);
    rdx(dtb_pkg::ADDR_CNT1, 32'hffff, 32'hffff);
    rdx(dtb_pkg::ADDR_CNT0, 32'h0, 32'hffff);
    pm.set_pins(1'b1, 1'b1, 1'b0);
    pm.pin_falls(1, 1);
    pm.pin_falls(0, 2);
    repeat (8) @(posedge pclk);
    rdx(dtb_pkg::ADDR_CNT1, 32'h0, 32'hffff);
    rdx(dtb_pkg::ADDR_CNT0, 32'h2, 32'hffff);
    wr(dtb_pkg::ADDR_STAT, 32'h2);
    rdx(dtb_pkg::ADDR_STAT, 32'h0, 32'h3);
    wr(dtb_pkg::ADDR_CTRL, 32'h0);
    done("gate");
    lf = lfsr(lf);
    r = {5'h1e, lf[2:0]};
    wr(dtb_pkg::ADDR_MASK, 32'h0);
    wr(dtb_pkg::ADDR_TBSEL, 32'h0);
    wr(dtb_pkg::ADDR_TONE, 32'h80);
    wr(dtb_pkg::ADDR_CNT0, {16'h0, r, 8'hff});
    wr(dtb_pkg::ADDR_CTRL, 32'h11);
    // First change only aligns; the second interval is measured
    for (int k = 0; k < 2; k++) begin
      t = tone_o;
      n = 0;
      while (tone_o === t && n < 2000) begin
        @(posedge pclk);
        n++;
      end
    end
    check(32'(n), 32'(4 * (256 - int'(r))));
    check({31'h0, tone_oe}, 32'h1);
    check({31'h0, irq}, 32'h0);
    rdx(dtb_pkg::ADDR_STAT, 32'h1, 32'h3);
    rdx(dtb_pkg::ADDR_CNT0, {16'h0, r, 8'h0}, 32'hff00);
    wr(dtb_pkg::ADDR_MASK, 32'h1);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    rdx(dtb_pkg::ADDR_VEC, 32'h0b, 32'hff);
    wr(dtb_pkg::ADDR_TONE, 32'hc0);
    pm.set_pins(1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge pclk);
    check({31'h0, tone_o}, 32'h1);
    pm.set_pins(1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge pclk);
    check({31'h0, tone_o}, 32'h0);
    wr(dtb_pkg::ADDR_TONE, 32'h0);
    repeat (3) @(posedge pclk);
    check({31'h0, tone_oe}, 32'h0);
    wr(dtb_pkg::ADDR_CTRL, 32'h0);
    repeat (8) @(posedge pclk);
    srv0 <= 1'b1;
    @(posedge pclk);
    srv0 <= 1'b0;
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    rdx(dtb_pkg::ADDR_STAT, 32'h0, 32'h3);
    done("reload_tone");
    end_sim();
  end
endmodule : tb_dual_timer_counter_buzzer
